// ---- ssp_socket_pkg.sv ----
// constants, field layouts and carriers for the socket status and power registers
// assumes an 8-bit indexed register port driven by host-side logic on clk_i
//
// Overview of operation
// R1 - reserved status and power bits read zero
// R2 - status bit 6 shows socket power on
// R3 - status bit 5 follows card ready line
// R4 - status bit 4 equals write-protect line
// R5 - status bit 3 is inverted detect two
// R6 - status bit 2 is inverted detect one
// R7 - memory card: bits 1:0 battery sense lines
// R8 - io card: bits 1:0 speaker, status change
// R9 - after reset bits 7:6 zero, rest live
// R10 - power bit 7 drives the socket output enable; supply and programming requests do not depend on it
// R11 - power bits 4:3 request supply voltage
// R12 - power bits 1:0 request programming voltage
// R13 - programming request ignored unless supply enabled
// R14 - power bits clear per power-event enable
// R15 - status register writes change nothing
package ssp_socket_pkg;

	// register indices on the socket register port
	localparam logic [7:0] SSP_IDX_STATUS = 8'h01;
	localparam logic [7:0] SSP_IDX_POWER = 8'h02;

	// status register field positions
	localparam int SSP_ST_POWER_ON_BIT = 6;
	localparam int SSP_ST_READY_BIT = 5;
	localparam int SSP_ST_WPROT_BIT = 4;
	localparam int SSP_ST_DET_TWO_BIT = 3;
	localparam int SSP_ST_DET_ONE_BIT = 2;
	localparam int SSP_ST_LINE_TWO_BIT = 1;
	localparam int SSP_ST_LINE_ONE_BIT = 0;

	// power control field positions
	localparam int SSP_PW_OE_BIT = 7;
	localparam int SSP_PW_VCC_LSB = 3;
	localparam int SSP_PW_VPP_LSB = 0;

	// bits of the power register that software may change
	localparam logic [7:0] SSP_PW_WR_MASK = 8'h9b;
	// reset values
	localparam logic [7:0] SSP_PW_RESET = 8'h00;
	localparam logic [7:0] SSP_ST_RESET = 8'h00;
	localparam logic [7:0] SSP_RDATA_RESET = 8'h00;

	// supply voltage request codes
	localparam logic [1:0] SSP_VCC_OFF = 2'h0;
	localparam logic [1:0] SSP_VCC_OFF_RSVD = 2'h1;
	localparam logic [1:0] SSP_VCC_5V = 2'h2;
	localparam logic [1:0] SSP_VCC_3V = 2'h3;

	// programming voltage request codes
	localparam logic [1:0] SSP_VPP_OFF = 2'h0;
	localparam logic [1:0] SSP_VPP_VCC = 2'h1;
	localparam logic [1:0] SSP_VPP_12V = 2'h2;
	localparam logic [1:0] SSP_VPP_OFF_RSVD = 2'h3;

	// live card pins and the two board resets, all asynchronous to clk_i
	typedef struct packed {
		logic ready;
		logic write_protect;
		logic detect_line_two;
		logic detect_line_one;
		logic battery_sense_line_two;
		logic battery_sense_line_one;
		logic speaker_out_line;
		logic status_change_line;
		logic global_reset_n;
		logic host_bus_reset_n;
	} ssp_pins_t;

	// idle level of the pin synchroniser: resets released, no card
	localparam ssp_pins_t SSP_PINS_IDLE = '{default: 1'b0, global_reset_n: 1'b1,
		host_bus_reset_n: 1'b1, detect_line_two: 1'b1, detect_line_one: 1'b1};

endpackage

// ---- ssp_socket_regs.sv ----
// socket status and power control register pair for one card socket
// assumes a one-cycle read or write strobe with index and data from host logic,
// card pins and the two board resets arriving asynchronously on pins
`timescale 1ns/100ps

module ssp_socket_regs
	import ssp_socket_pkg::*;
#(
	parameter int INDEX_W = 8 // width of the register index
) (
	input wire logic clk_i,
	input wire logic srst_i,
	// register port
	input wire logic [INDEX_W-1:0] reg_index_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// same-domain controls from neighbouring registers
	input wire logic pme_enable_i,
	input wire logic card_is_io_i,
	// card pins
	input wire logic ready_i,
	input wire logic write_protect_i,
	input wire logic detect_line_two_i,
	input wire logic detect_line_one_i,
	input wire logic battery_sense_line_two_i,
	input wire logic battery_sense_line_one_i,
	input wire logic speaker_out_line_i,
	input wire logic status_change_line_i,
	// board resets, active low
	input wire logic global_reset_n_i,
	input wire logic host_bus_reset_n_i,
	// socket controls
	output logic socket_output_enable_o,
	output logic [1:0] supply_voltage_request_o,
	output logic [1:0] program_voltage_request_o,
	output logic socket_power_on_status_o
);

	// the index must at least reach both registers
	generate
		if (INDEX_W < 2) begin : g_bad_width
			$error("ssp_socket_regs: INDEX_W too small");
		end
	endgenerate

	// raw pin bundle before synchronising
	ssp_pins_t pins_raw;
	// first synchroniser stage, read only by the second
	ssp_pins_t pins_meta_reg;
	// second stage, safe for logic
	ssp_pins_t pins_sync_reg;

	// stored power control byte
	logic [7:0] power_reg;
	logic [7:0] power_next;
	// registered view of the status byte
	logic [7:0] status_reg;
	logic [7:0] status_next;
	// read port flops
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	// gated programming request
	logic [1:0] vpp_reg;
	logic [1:0] vpp_next;
	logic power_on_reg;

	// decode wires
	logic hit_status;
	logic hit_power;
	logic wr_power;
	logic power_clear;
	logic vcc_enabled;
	logic [1:0] low_lines;
	logic [7:0] status_live;
	logic [7:0] read_sel;

	assign pins_raw = '{
		ready: ready_i,
		write_protect: write_protect_i,
		detect_line_two: detect_line_two_i,
		detect_line_one: detect_line_one_i,
		battery_sense_line_two: battery_sense_line_two_i,
		battery_sense_line_one: battery_sense_line_one_i,
		speaker_out_line: speaker_out_line_i,
		status_change_line: status_change_line_i,
		global_reset_n: global_reset_n_i,
		host_bus_reset_n: host_bus_reset_n_i
	};

	// two-flop synchroniser for every pin; reset parks it at the idle level
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pins_meta_reg <= SSP_PINS_IDLE;
			pins_sync_reg <= SSP_PINS_IDLE;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_sync_reg <= pins_meta_reg;
		end
	end

	// address decode; indices above the pair read as zero
	assign hit_status = (reg_index_i == INDEX_W'(SSP_IDX_STATUS));
	assign hit_power = (reg_index_i == INDEX_W'(SSP_IDX_POWER));
	// R15 status writes ignored
	// only the power index accepts a write; a status write falls through
	assign wr_power = reg_wr_i & hit_power;

	// R14 reset source selection
	// with power events enabled the bus reset must not drop socket power
	assign power_clear = srst_i | ~pins_sync_reg.global_reset_n
		| (~pins_sync_reg.host_bus_reset_n & ~pme_enable_i);

	// R11 supply request decode
	// only 5 V and 3 V codes count as powered; the reserved code stays off
	assign vcc_enabled = (power_reg[SSP_PW_VCC_LSB +: 2] == SSP_VCC_5V)
		| (power_reg[SSP_PW_VCC_LSB +: 2] == SSP_VCC_3V);

	// R1 reserved power bits
	// masked write keeps reserved bits at zero whatever is written
	assign power_next = wr_power ? (reg_wdata_i & SSP_PW_WR_MASK) : power_reg;

	// R13 programming request gating
	// without supply the field is ignored and the request shows off
	assign vpp_next = vcc_enabled ? power_reg[SSP_PW_VPP_LSB +: 2] : SSP_VPP_OFF;

	// R7 battery lines on memory card
	// R8 speaker and status change on io card
	// the same two bits carry either pair, undecoded
	assign low_lines = card_is_io_i
		? {pins_sync_reg.speaker_out_line, pins_sync_reg.status_change_line}
		: {pins_sync_reg.battery_sense_line_two, pins_sync_reg.battery_sense_line_one};

	// live status byte assembled bit by bit
	always_comb begin
		status_live = 8'h00;
		// R1 reserved status bit
		status_live[7] = 1'b0;
		// R2 power on indication
		status_live[SSP_ST_POWER_ON_BIT] = vcc_enabled;
		// R3 ready mirror
		status_live[SSP_ST_READY_BIT] = pins_sync_reg.ready;
		// R4 write protect mirror
		status_live[SSP_ST_WPROT_BIT] = pins_sync_reg.write_protect;
		// R5 detect two inverted
		status_live[SSP_ST_DET_TWO_BIT] = ~pins_sync_reg.detect_line_two;
		// R6 detect one inverted
		status_live[SSP_ST_DET_ONE_BIT] = ~pins_sync_reg.detect_line_one;
		status_live[SSP_ST_LINE_TWO_BIT] = low_lines[1];
		status_live[SSP_ST_LINE_ONE_BIT] = low_lines[0];
	end
	assign status_next = status_live;

	// read data selection; anything unmapped reads zero
	assign read_sel = hit_status ? status_reg : (hit_power ? power_reg : 8'h00);
	// read data held between reads so the bus sees a stable byte
	assign rdata_next = reg_rd_i ? read_sel : rdata_reg;

	// R14 power control storage
	// R10 output enable stored here
	always_ff @(posedge clk_i) begin
		if (power_clear) begin
			power_reg <= SSP_PW_RESET;
			vpp_reg <= SSP_VPP_OFF;
			power_on_reg <= 1'b0;
		end else begin
			power_reg <= power_next;
			vpp_reg <= vpp_next;
			power_on_reg <= vcc_enabled;
		end
	end

	// R9 status snapshot after reset
	// bits 7:6 are zero out of reset; the rest refill from pins each cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_reg <= SSP_ST_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// read port: data one cycle after the strobe with a valid pulse
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_reg <= SSP_RDATA_RESET;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= reg_rd_i;
		end
	end

	// outputs, each straight from a flop
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	// R10 output enable drive
	assign socket_output_enable_o = power_reg[SSP_PW_OE_BIT];
	// R11 supply request drive
	assign supply_voltage_request_o = power_reg[SSP_PW_VCC_LSB +: 2];
	// R12 programming request drive
	assign program_voltage_request_o = vpp_reg;
	// power indication lags the request by one cycle, as the status bit does, except that a clear drops it together with the request
	assign socket_power_on_status_o = power_on_reg;

endmodule // ssp_socket_regs

// ---- ssp_socket_regs_assertions.sv ----
// port checker for the socket status and power register pair
// assumes board reset pins stay low for at least four clocks when pulsed
`timescale 1ns/100ps
module ssp_socket_regs_assertions
	import ssp_socket_pkg::*;
#(
	parameter int INDEX_W = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [INDEX_W-1:0] reg_index_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic global_reset_n_i,
	input wire logic host_bus_reset_n_i,
	input wire logic socket_output_enable_o,
	input wire logic [1:0] supply_voltage_request_o,
	input wire logic [1:0] program_voltage_request_o,
	input wire logic socket_power_on_status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// board resets high for four clocks, so no clear can race a write
	// a clear drops the power flag at once, so its one-cycle lag checks also wait for quiet pins
	logic [3:0] quiet_reg;
	always_ff @(posedge clk_i) begin
		quiet_reg <= {quiet_reg[2:0], global_reset_n_i & host_bus_reset_n_i};
	end
	wire wr_pw = reg_wr_i && reg_index_i == INDEX_W'(SSP_IDX_POWER) && (&quiet_reg);
	a_write_oe: assert property (wr_pw |=> socket_output_enable_o == $past(reg_wdata_i[7]))
		else $error("output enable differs from written bit");
	a_write_vcc: assert property (wr_pw |=> supply_voltage_request_o == $past(reg_wdata_i[4:3]))
		else $error("supply request differs from written field");
	a_vpp_gated: assert property (!supply_voltage_request_o[1] |=> program_voltage_request_o == 2'h0)
		else $error("programming request passed with supply off");
	a_power_on_flag: assert property ((&quiet_reg) |-> socket_power_on_status_o == $past(supply_voltage_request_o[1]))
		else $error("power on flag wrong");
	a_status_top_bits: assert property (reg_rvalid_o && (&quiet_reg)
		&& $past(reg_index_i) == INDEX_W'(SSP_IDX_STATUS)
		|-> reg_rdata_o[7:6] == {1'b0, $past(socket_power_on_status_o)})
		else $error("status bits 7:6 wrong");
	a_power_read_back: assert property (reg_rvalid_o && $past(reg_index_i) == INDEX_W'(SSP_IDX_POWER)
		|-> reg_rdata_o[7:2] == {$past(socket_output_enable_o), 2'b00, $past(supply_voltage_request_o), 1'b0})
		else $error("power read back wrong");
	a_unmapped_zero: assert property (reg_rvalid_o && $past(reg_index_i) > INDEX_W'(SSP_IDX_POWER)
		|-> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_global_clear: assert property ((!global_reset_n_i) [*4] |-> !socket_output_enable_o
		&& supply_voltage_request_o == 2'h0)
		else $error("global reset did not clear power");
	c_write: cover property (wr_pw ##1 socket_output_enable_o);
	c_power_on: cover property (reg_rvalid_o && reg_rdata_o[6]);
	c_clear: cover property ((!host_bus_reset_n_i) [*4]);
endmodule // ssp_socket_regs_assertions
bind ssp_socket_regs ssp_socket_regs_assertions #(.INDEX_W(INDEX_W)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
	.reg_index_i(reg_index_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .global_reset_n_i(global_reset_n_i), .host_bus_reset_n_i(host_bus_reset_n_i),
	.socket_output_enable_o(socket_output_enable_o), .supply_voltage_request_o(supply_voltage_request_o),
	.program_voltage_request_o(program_voltage_request_o), .socket_power_on_status_o(socket_power_on_status_o));

// ---- ssp_card_model.sv ----
// card in the socket: drives the live card pins
// assumes the bench picks insertion and line levels at the falling edge
`timescale 1ns/100ps
module ssp_card_model
	import ssp_socket_pkg::*;
(
	input wire logic present_i,
	input wire logic [5:0] lines_i,
	output ssp_pins_t pins_o
);
	// detect lines pulled high in the socket, grounded by a card
	assign pins_o = {lines_i[5:4], ~present_i, ~present_i, lines_i[3:0], 2'b11};
endmodule // ssp_card_model

// ---- ssp_socket_regs_tb_top.sv ----
// self-checking bench for the socket status and power registers
// assumes the card model and the bind checker are compiled alongside
`timescale 1ns/100ps
module ssp_socket_regs_tb_top import ssp_socket_pkg::*; ;
	logic clk_i = 0, srst_i = 1, rd = 0, wr = 0, pme = 0, io = 0, gr_n = 1, br_n = 1, present = 0;
	logic [7:0] idx = 0, wdata = 0, wd;
	logic [5:0] lines = 0;
	logic [7:0] rdata;
	logic rvalid, oe, pon;
	logic [1:0] vcc, vpp;
	ssp_pins_t pins;
	int failures = 0, n_tests = 0;
	always #20 clk_i = ~clk_i;
	ssp_card_model u_ssp_card_model (.present_i(present), .lines_i(lines), .pins_o(pins));
	ssp_socket_regs u_ssp_socket_regs (.clk_i(clk_i), .srst_i(srst_i), .reg_index_i(idx), .reg_rd_i(rd),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .pme_enable_i(pme),
		.card_is_io_i(io), .ready_i(pins.ready), .write_protect_i(pins.write_protect),
		.detect_line_two_i(pins.detect_line_two), .detect_line_one_i(pins.detect_line_one),
		.battery_sense_line_two_i(pins.battery_sense_line_two), .battery_sense_line_one_i(pins.battery_sense_line_one),
		.speaker_out_line_i(pins.speaker_out_line), .status_change_line_i(pins.status_change_line),
		.global_reset_n_i(gr_n), .host_bus_reset_n_i(br_n), .socket_output_enable_o(oe),
		.supply_voltage_request_o(vcc), .program_voltage_request_o(vpp), .socket_power_on_status_o(pon));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// strobes rise and fall at falling edges, answer seen one edge later
	task rd_chk(input logic [7:0] i, input logic [7:0] exp);
		@(negedge clk_i);
		rd = 1;
		idx = i;
		@(negedge clk_i);
		rd = 0;
		chk({7'h0, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask
	task wr_reg(input logic [7:0] i, input logic [7:0] d);
		@(negedge clk_i);
		wr = 1;
		idx = i;
		wdata = d;
		@(negedge clk_i);
		wr = 0;
	endtask
	// live status as the bench set the card lines
	function logic [7:0] st_exp(input logic on);
		return {1'b0, on, lines[5:4], present, present, io ? lines[1:0] : lines[3:2]};
	endfunction
	task tally_and_finish;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h92df));
		repeat (12) @(negedge clk_i);
		srst_i = 0;
		repeat (3) @(negedge clk_i);
		rd_chk(8'h01, st_exp(1'b0));
		rd_chk(8'h02, 8'h00);
		// first sixteen walk every supply and programming code, reserved bits set
		for (int k = 0; k < 48; k++) begin
			wd = (k < 16) ? {3'b111, k[3:2], 1'b1, k[1:0]} : 8'($urandom);
			wr_reg(8'h02, wd);
			present = 1'($urandom);
			lines = 6'($urandom);
			io = 1'($urandom);
			wr_reg(8'h01, 8'($urandom));
			wr_reg(8'h03 + 8'($urandom_range(200)), 8'hff);
			repeat (4) @(negedge clk_i);
			chk({oe, 2'b0, vcc, 1'b0, vpp}, {wd[7], 2'b0, wd[4:3], 1'b0, wd[4] ? wd[1:0] : 2'b0});
			chk({7'h0, pon}, {7'h0, wd[4]});
			rd_chk(8'h02, wd & 8'h9b);
			rd_chk(8'h01, st_exp(wd[4]));
			rd_chk(8'h80 | 8'($urandom), 8'h00);
		end
		// global clear with events on, bus reset with events on and off
		for (int c = 0; c < 3; c++) begin
			wr_reg(8'h02, 8'h9b);
			pme = (c != 2);
			gr_n = (c != 0);
			br_n = (c == 0);
			repeat (5) @(negedge clk_i);
			gr_n = 1;
			br_n = 1;
			repeat (3) @(negedge clk_i);
			rd_chk(8'h02, (c == 1) ? 8'h9b : 8'h00);
		end
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		tally_and_finish();
	end
endmodule // ssp_socket_regs_tb_top
